/* File: rtl/bcr_defs.svh */
// Register offsets, field positions, reset values and timing counts.
// Assumes an 8-bit register port with an 8-bit byte address.
`ifndef BCR_DEFS_SVH
`define BCR_DEFS_SVH

`define BCR_CLK_MHZ            125
`define BCR_MEAS_MIN_US        50
`define BCR_MEAS_CYC           (`BCR_MEAS_MIN_US * `BCR_CLK_MHZ)
`define BCR_OFS_VSET           8'h00
`define BCR_OFS_FPWM           8'h06
`define BCR_OFS_FLAGS0         8'h0D
`define BCR_OFS_FLAGS1         8'h0E
`define BCR_OFS_MASK0          8'h0F
`define BCR_OFS_GENERAL        8'h10
`define BCR_OFS_RESET          8'h11
`define BCR_OFS_PFM_LEV        8'h19
`define BCR_OFS_PHASE_LEV      8'h1F
`define BCR_OFS_SEL            8'h21
`define BCR_OFS_LOADLO         8'h22
`define BCR_OFS_MASK2          8'h2E
// Field positions
`define BCR_VSET_ON_BIT        7
`define BCR_GEN_LP_BIT         0
`define BCR_GEN_SS_BIT         1
`define BCR_RESET_SW_BIT       0
`define BCR_F1_READY_BIT       0
`define BCR_F1_UVLO_BIT        1
`define BCR_F1_OVP_BIT         2
`define BCR_F1_THSD_BIT        3
`define BCR_MASK2_READY_BIT    0
// Reset values
`define BCR_VSET_RST           8'h00
`define BCR_CTRL_RST           8'h00
// Full scale: 20 A at 10 mA per count
`define BCR_CURR_MAX           11'h7D0
// PFM trip point range, counts of 10 mA (100 to 2620 mA)
`define BCR_PFM_MIN            11'h00A
`define BCR_PFM_STEP_SHIFT     2
// Phase adding step, counts of 10 mA per extra phase at level 0
`define BCR_PHASE_BASE         11'h064
`define BCR_PHASES             3'h6

`endif

/* File: rtl/bcr_pkg.sv */
// Types shared by the sequencer.
// Assumes bcr_defs.svh supplies all numbers.
package bcr_pkg;
    typedef enum logic [1:0] {
        BCR_MEAS_IDLE = 2'b00,
        BCR_MEAS_RUN  = 2'b01,
        BCR_MEAS_DONE = 2'b10
    } bcr_meas_t;

    typedef enum logic [1:0] {
        BCR_MODE_PWM   = 2'b00,
        BCR_MODE_PFM   = 2'b01,
        BCR_MODE_LPPFM = 2'b10,
        BCR_MODE_OFF   = 2'b11
    } bcr_mode_t;
endpackage

/* File: rtl/bcr_sequencer.sv */
// Digital control and reset sequencer for a six-core multiphase buck.
// Assumes a decoded byte register port, synchronous pins, one 125 MHz clock.
//
// Summary of operation
// - Any write to the selection register launches a new load measurement.
// - A measurement lasts at least 50 us before its result is declared.
// - Ready flag clears at launch, sets at completion, reads 0 after power-on reset.
// - Result is 11-bit unsigned, 10 mA per count, up to 20 A.
// - Low eight bits at 0x22, high three bits in selection register top.
// - Measurement completion raises an interrupt unless its mask bit is set.
// - While sleep input is asserted the converter runs low-power PFM.
// - A control register bit also selects low-power PFM.
// - PFM/PWM chosen automatically; trip point 100 to 2620 mA by register.
// - Active phase count follows load in PWM mode to maximise efficiency; one phase in PFM.
// - Spread spectrum mode varies switching frequency randomly when enabled.
// - POR release, settings load, standby; host programs, then lifts reset.
// - Converter runs only with the enable bit set and the active-low reset input high.
// - Soft reset only on write 1 then write 0; control registers default.
// - Fault flags keep their values across a soft reset.
// - Internal power-on reset on main supply rise only; I/O supply loss with reset input high starts fast power-down instead.
// - After power-on, registers hold defaults until flagged or written.
// - Falling edge of hardware reset input starts a hardware reset.
// - Overvoltage, undervoltage, thermal shutdown or I/O loss with reset input high start fast power-down.
// - Hardware reset acts after power-down; writes still taken meanwhile.
// - Interrupt output low while any unmasked flag is set, released when cleared.
`timescale 1ns/100ps
`include "bcr_defs.svh"

module bcr_sequencer (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        clk_en_i,
    input  wire logic        por_i,
    input  wire logic        io_supply_level_i,
    input  wire logic        hw_reset_n_i,
    input  wire logic        sleep_request_n_i,
    input  wire logic        ovp_i,
    input  wire logic        uvlo_i,
    input  wire logic        thermal_shutdown_i,
    input  wire logic        pwrdn_done_i,
    input  wire logic [2:0]  core_sel_current_i,
    input  wire logic [10:0] measured_current_value_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    output logic             converter_on_o,
    output logic      [1:0]  mode_o,
    output logic      [2:0]  active_phases_o,
    output logic             spread_dither_o,
    output logic             fast_pwrdn_o,
    output logic             interrupt_n_o
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [7:0]        vset;
        logic [7:0]        fpwm;
        logic [7:0]        mask0;
        logic [7:0]        general;
        logic [7:0]        pfm_lev;
        logic [7:0]        phase_lev;
        logic [7:0]        mask2;
        logic [4:0]        sel;
        logic [7:0]        flags1;
        logic              sw_armed;
        logic              hw_n_d;
        logic              hw_pending;
        logic              io_d;
        bcr_pkg::bcr_meas_t meas;
        logic [12:0]       meas_cnt;
        logic [10:0]       result;
        logic [10:0]       avg_i;
        logic [15:0]       lfsr;
        logic [7:0]        rdata;
        logic              on;
        bcr_pkg::bcr_mode_t mode;
        logic [2:0]        phases;
        logic              dither;
        logic              pwrdn;
        logic              int_n;
    } bcr_state_t;

    bcr_state_t st_reg;
    bcr_state_t st_next;

    logic        sel_wr;
    logic        lp_req;
    logic [10:0] trip;
    logic [10:0] phase_step;
    logic [2:0]  want_phases;
    logic        fault;

    localparam logic [12:0] MEAS_LAST = 13'(`BCR_MEAS_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_next     = st_reg;
        sel_wr      = reg_wr_i && (reg_addr_i == `BCR_OFS_SEL);
        fault       = ovp_i || uvlo_i || thermal_shutdown_i
                      || (!io_supply_level_i && hw_reset_n_i);
        lp_req      = !sleep_request_n_i || st_reg.general[`BCR_GEN_LP_BIT];
        trip        = `BCR_PFM_MIN
                      + 11'({st_reg.pfm_lev[5:0], 2'b00}) ;
        phase_step  = `BCR_PHASE_BASE + 11'({st_reg.phase_lev, 1'b0});
        want_phases = 3'h1;
        // Ladder kept short: one added phase per step of load
        for (int k = 1; k < 6; k++) begin
            if (st_reg.avg_i > 11'(phase_step * k)) begin
                want_phases = 3'(k + 1);
            end
        end

        st_next.hw_n_d = hw_reset_n_i;
        st_next.io_d   = io_supply_level_i;

        // Flags: hardware sets, host write-1 clears all but ready; set wins
        if (reg_wr_i && reg_addr_i == `BCR_OFS_FLAGS1) begin
            st_next.flags1 = st_reg.flags1 & ~reg_wdata_i;
            st_next.flags1[`BCR_F1_READY_BIT] = st_reg.flags1[`BCR_F1_READY_BIT];
        end
        if (ovp_i)              st_next.flags1[`BCR_F1_OVP_BIT]  = 1'b1;
        if (uvlo_i)             st_next.flags1[`BCR_F1_UVLO_BIT] = 1'b1;
        if (thermal_shutdown_i) st_next.flags1[`BCR_F1_THSD_BIT] = 1'b1;

        // Register writes stay open while the reset input is low
        if (reg_wr_i) begin
            case (reg_addr_i)
                `BCR_OFS_VSET:      st_next.vset      = reg_wdata_i;
                `BCR_OFS_FPWM:      st_next.fpwm      = reg_wdata_i;
                `BCR_OFS_MASK0:     st_next.mask0     = reg_wdata_i;
                `BCR_OFS_GENERAL:   st_next.general   = reg_wdata_i;
                `BCR_OFS_PFM_LEV:   st_next.pfm_lev   = reg_wdata_i;
                `BCR_OFS_PHASE_LEV: st_next.phase_lev = reg_wdata_i;
                `BCR_OFS_MASK2:     st_next.mask2     = reg_wdata_i;
                `BCR_OFS_SEL:       st_next.sel       = reg_wdata_i[4:0];
                default: ;
            endcase
        end

        // Measurement sequencer
        case (st_reg.meas)
            bcr_pkg::BCR_MEAS_IDLE, bcr_pkg::BCR_MEAS_DONE: begin
                st_next.meas_cnt = 13'h0000;
            end
            bcr_pkg::BCR_MEAS_RUN: begin
                if (st_reg.meas_cnt == MEAS_LAST) begin
                    st_next.meas   = bcr_pkg::BCR_MEAS_DONE;
                    st_next.result = (measured_current_value_i > `BCR_CURR_MAX)
                                     ? `BCR_CURR_MAX : measured_current_value_i;
                    st_next.flags1[`BCR_F1_READY_BIT] = 1'b1;
                end else begin
                    st_next.meas_cnt = st_reg.meas_cnt + 13'h0001;
                end
            end
            default: st_next.meas = bcr_pkg::BCR_MEAS_IDLE;
        endcase
        if (sel_wr) begin
            st_next.meas     = bcr_pkg::BCR_MEAS_RUN;
            st_next.meas_cnt = 13'h0000;
            st_next.flags1[`BCR_F1_READY_BIT] = 1'b0;
            // Result from previous run stays until this run completes
        end

        // Soft reset: write 1 then the very next write of 0
        if (reg_wr_i && reg_addr_i == `BCR_OFS_RESET) begin
            st_next.sw_armed = reg_wdata_i[`BCR_RESET_SW_BIT];
        end else if (reg_wr_i) begin
            st_next.sw_armed = 1'b0;
        end

        // Hardware reset waits for power-down completion
        if (st_reg.hw_n_d && !hw_reset_n_i) begin
            st_next.hw_pending = 1'b1;
        end

        if ((reg_wr_i && reg_addr_i == `BCR_OFS_RESET && st_reg.sw_armed
             && !reg_wdata_i[`BCR_RESET_SW_BIT])
            || (st_reg.hw_pending && pwrdn_done_i)) begin
            // Control registers back to defaults; flags, vset, select kept
            st_next.fpwm       = `BCR_CTRL_RST;
            st_next.mask0      = `BCR_CTRL_RST;
            st_next.general    = `BCR_CTRL_RST;
            st_next.pfm_lev    = `BCR_CTRL_RST;
            st_next.phase_lev  = `BCR_CTRL_RST;
            st_next.mask2      = `BCR_CTRL_RST;
            st_next.sw_armed   = 1'b0;
            st_next.hw_pending = 1'b0;
        end

        // Current average for mode and phase decisions
        // 14 bits hold 7 * 2047 + 2047 without wrapping
        st_next.avg_i = 11'(({3'b000, st_reg.avg_i} * 14'h0007
                             + {3'b000, measured_current_value_i}) >> 3);
        st_next.lfsr  = {st_reg.lfsr[14:0],
                         st_reg.lfsr[15] ^ st_reg.lfsr[13]
                         ^ st_reg.lfsr[12] ^ st_reg.lfsr[10]};

        // Converter control
        st_next.pwrdn  = fault;
        st_next.on     = st_reg.vset[`BCR_VSET_ON_BIT] && hw_reset_n_i
                         && !fault && !st_reg.hw_pending;
        if (!st_next.on) begin
            st_next.mode = bcr_pkg::BCR_MODE_OFF;
        end else if (lp_req) begin
            st_next.mode = bcr_pkg::BCR_MODE_LPPFM;
        end else if (st_reg.fpwm[0] || st_reg.avg_i >= trip) begin
            st_next.mode = bcr_pkg::BCR_MODE_PWM;
        end else begin
            st_next.mode = bcr_pkg::BCR_MODE_PFM;
        end
        st_next.phases = (st_next.mode == bcr_pkg::BCR_MODE_PWM) ? want_phases
                         : ((st_next.on) ? 3'h1 : 3'h0);
        st_next.dither = st_reg.general[`BCR_GEN_SS_BIT] && st_reg.lfsr[0];

        // Interrupt: any unmasked flag pulls low
        st_next.int_n = !(|(st_next.flags1
                         & ~{7'h00, st_reg.mask2[`BCR_MASK2_READY_BIT]}));

        // Read port
        case (reg_addr_i)
            `BCR_OFS_VSET:      st_next.rdata = st_reg.vset;
            `BCR_OFS_FPWM:      st_next.rdata = st_reg.fpwm;
            `BCR_OFS_FLAGS1:    st_next.rdata = st_reg.flags1;
            `BCR_OFS_MASK0:     st_next.rdata = st_reg.mask0;
            `BCR_OFS_GENERAL:   st_next.rdata = st_reg.general;
            `BCR_OFS_PFM_LEV:   st_next.rdata = st_reg.pfm_lev;
            `BCR_OFS_PHASE_LEV: st_next.rdata = st_reg.phase_lev;
            `BCR_OFS_MASK2:     st_next.rdata = st_reg.mask2;
            `BCR_OFS_SEL:       st_next.rdata = {st_reg.result[10:8], st_reg.sel};
            `BCR_OFS_LOADLO:    st_next.rdata = st_reg.result[7:0];
            default:            st_next.rdata = 8'h00;
        endcase
        if (!reg_rd_i) st_next.rdata = st_reg.rdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers; power-on reset restores every factory value

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg        <= '0;
            st_reg.vset   <= `BCR_VSET_RST;
            st_reg.meas   <= bcr_pkg::BCR_MEAS_IDLE;
            st_reg.mode   <= bcr_pkg::BCR_MODE_OFF;
            st_reg.lfsr   <= 16'hACE1;
            st_reg.int_n  <= 1'b1;
            // Pin idles low at power-up; no false falling edge
            st_reg.hw_n_d <= 1'b0;
        end else if (por_i) begin
            st_reg        <= '0;
            st_reg.meas   <= bcr_pkg::BCR_MEAS_IDLE;
            st_reg.mode   <= bcr_pkg::BCR_MODE_OFF;
            st_reg.lfsr   <= 16'hACE1;
            st_reg.int_n  <= 1'b1;
            st_reg.hw_n_d <= 1'b0;
        end else if (clk_en_i) begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_o     = st_reg.rdata;
    assign converter_on_o  = st_reg.on;
    assign mode_o          = st_reg.mode;
    assign active_phases_o = st_reg.phases;
    assign spread_dither_o = st_reg.dither;
    assign fast_pwrdn_o    = st_reg.pwrdn;
    assign interrupt_n_o   = st_reg.int_n;

endmodule

/* File: testbench/bcr_seq_asserts.sv */
// Port checker for the sequencer.
// Assumes one clock domain and only the top module's ports.
`timescale 1ns/100ps
module bcr_seq_asserts (
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    input wire logic       clk_en_i,
    input wire logic       por_i,
    input wire logic       io_supply_level_i,
    input wire logic       hw_reset_n_i,
    input wire logic       sleep_request_n_i,
    input wire logic       ovp_i,
    input wire logic       uvlo_i,
    input wire logic       thermal_shutdown_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       converter_on_o,
    input wire logic [1:0] mode_o,
    input wire logic [2:0] active_phases_o,
    input wire logic       fast_pwrdn_o,
    input wire logic       interrupt_n_o
);
default clocking @(posedge ref_clk_i); endclocking
default disable iff (rst_i);
wire logic flt = ovp_i | uvlo_i | thermal_shutdown_i;
////////////////////////////////////////
property p_pwrdn; clk_en_i && !por_i && (flt || (!io_supply_level_i && hw_reset_n_i))
    |=> fast_pwrdn_o;
endproperty
a_pwrdn: assert property (p_pwrdn) else $error("no power-down on cause");
property p_flag_irq; clk_en_i && !por_i && flt |-> ##[1:2] !interrupt_n_o; endproperty
a_flag_irq: assert property (p_flag_irq) else $error("no interrupt on fault");
property p_sleep; (clk_en_i && !sleep_request_n_i)[*3] |-> mode_o inside {2'h2, 2'h3};
endproperty
a_sleep: assert property (p_sleep) else $error("sleep without low-power mode");
property p_hwrst; $fell(hw_reset_n_i) && clk_en_i |-> ##[1:2] !converter_on_o; endproperty
a_hwrst: assert property (p_hwrst) else $error("converter on after reset fall");
property p_off_ph; mode_o == 2'h3 |-> active_phases_o == 3'h0; endproperty
a_off_ph: assert property (p_off_ph) else $error("phases active while off");
property p_pfm_ph; mode_o inside {2'h1, 2'h2} |-> active_phases_o == 3'h1; endproperty
a_pfm_ph: assert property (p_pfm_ph) else $error("pfm phase count wrong");
property p_max_ph; mode_o == 2'h0 |-> active_phases_o inside {[3'h1:3'h6]}; endproperty
a_max_ph: assert property (p_max_ph) else $error("pwm phase count out of range");
property p_rd_hold; !$past(reg_rd_i) && !$past(por_i) |-> $stable(reg_rdata_o); endproperty
a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
c_irq: cover property (!interrupt_n_o);
c_lp: cover property (mode_o == 2'h2);
c_pwm: cover property (mode_o == 2'h0 && active_phases_o > 3'h1);
endmodule
bind bcr_sequencer bcr_seq_asserts chk_i (.ref_clk_i, .rst_i, .clk_en_i, .por_i,
    .io_supply_level_i, .hw_reset_n_i, .sleep_request_n_i, .ovp_i, .uvlo_i,
    .thermal_shutdown_i, .reg_rd_i, .reg_rdata_o, .converter_on_o, .mode_o,
    .active_phases_o, .fast_pwrdn_o, .interrupt_n_o);

/* File: testbench/bcr_host_model.sv */
// Host processor model: register port master plus reset and sleep pins.
// Assumes the sequencer samples strobes on the rising clock edge.
`timescale 1ns/100ps
module bcr_host_model #(parameter int IO_WAIT = 16) (
    input  wire logic       ref_clk_i,
    input  wire logic [7:0] rdata_i,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            hw_reset_n_o,
    output logic            sleep_request_n_o
);
// Reset input low until settings are programmed
initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    hw_reset_n_o = 1'b0;
    sleep_request_n_o = 1'b1;
end
// Supply wait shortened, run length matters more
task automatic start();
    repeat (IO_WAIT) @(posedge ref_clk_i);
endtask
// Address and data inverted when idle so stale values never match
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
endtask
task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge ref_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1 d = rdata_i;
endtask
// Sleep only at light load, released ahead of load steps
task automatic pins(input logic rst_n, input logic slp_n);
    @(posedge ref_clk_i);
    hw_reset_n_o <= rst_n;
    sleep_request_n_o <= slp_n;
endtask
endmodule

/* File: testbench/test_bcr_sequencer.sv */
// Self-checking bench for the sequencer.
// Assumes the host model and checker are compiled alongside.
`timescale 1ns/100ps
module test_bcr_sequencer;
logic ref_clk_i = 1'b0;
logic rst_i = 1'b1;
logic por_i = 1'b0;
logic io_lvl = 1'b1;
logic pd_done = 1'b0;
logic [2:0] flt = 3'h0;
logic [10:0] cur = 11'h000;
logic wr, rd, rst_n, slp_n, conv, pdn, irq_n, dith;
logic [7:0] addr, wdata, rdata;
logic [1:0] mode;
logic [2:0] ph;
int n_fail = 0;
int n_checks = 0;
always #4 ref_clk_i = ~ref_clk_i;
bcr_sequencer bcr_sequencer_i (.ref_clk_i, .rst_i, .clk_en_i(1'b1), .por_i,
    .io_supply_level_i(io_lvl), .hw_reset_n_i(rst_n), .sleep_request_n_i(slp_n),
    .ovp_i(flt[1]), .uvlo_i(flt[0]), .thermal_shutdown_i(flt[2]), .pwrdn_done_i(pd_done),
    .core_sel_current_i(3'h0), .measured_current_value_i(cur), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .converter_on_o(conv), .mode_o(mode), .active_phases_o(ph), .spread_dither_o(dith),
    .fast_pwrdn_o(pdn), .interrupt_n_o(irq_n));
bcr_host_model #(.IO_WAIT(62500)) bcr_host_model_i (.ref_clk_i, .rdata_i(rdata), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wdata), .hw_reset_n_o(rst_n),
    .sleep_request_n_o(slp_n));
////////////////////////////////////////
task automatic chk(input string nm, input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp) begin
        n_fail++;
        $display("Error %s expected %h seen %h", nm, exp, got);
    end
endtask
task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    bcr_host_model_i.rd(a, d);
    chk(nm, 11'(d), 11'(e));
endtask
task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
endtask
task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
// Supply wait, sleep lead time and two measurements dominate the run time
initial begin
    cyc(95000);
    n_fail++;
    final_report();
end
////////////////////////////////////////
initial begin
    cyc(8);
    rst_i <= 1'b0;
    bcr_host_model_i.start();
    rchk("flags", 8'h0E, 8'h00);
    rchk("unmapped", 8'hFF, 8'h00);
    bcr_host_model_i.wr(8'h00, 8'h80);
    bcr_host_model_i.pins(1'b1, 1'b1);
    cyc(2);
    chk("conv_on", 11'(conv), 11'h1);
    $display("Start-up done");
    @(posedge ref_clk_i) cur <= 11'h5A3;
    bcr_host_model_i.wr(8'h21, 8'h03);
    rchk("ready_clr", 8'h0E, 8'h00);
    cyc(6200);
    rchk("ready_early", 8'h0E, 8'h00);
    cyc(60);
    rchk("ready_set", 8'h0E, 8'h01);
    chk("irq", 11'(irq_n), 11'h0);
    rchk("res_low", 8'h22, 8'hA3);
    rchk("res_high", 8'h21, 8'hA3);
    bcr_host_model_i.wr(8'h2E, 8'h01);
    cyc(3);
    chk("irq_mask", 11'(irq_n), 11'h1);
    bcr_host_model_i.wr(8'h11, 8'h01);
    bcr_host_model_i.wr(8'h11, 8'h00);
    rchk("mask_dflt", 8'h2E, 8'h00);
    rchk("ready_kept", 8'h0E, 8'h01);
    $display("Measurement done");
    cyc(100);
    chk("mode_pwm", 11'(mode), 11'h0);
    chk("phases", 11'(ph), 11'h6);
    @(posedge ref_clk_i) cur <= 11'd2;
    cyc(200);
    bcr_host_model_i.pins(1'b1, 1'b0);
    cyc(4);
    chk("mode_sleep", 11'(mode), 11'h2);
    bcr_host_model_i.pins(1'b1, 1'b1);
    cyc(12500);
    cur <= 11'd20;
    cyc(200);
    chk("mode_light", 11'(mode), 11'h0);
    rchk("res_hold", 8'h22, 8'hA3);
    bcr_host_model_i.wr(8'h19, 8'h03);
    cyc(200);
    chk("mode_pfm", 11'(mode), 11'h1);
    bcr_host_model_i.wr(8'h10, 8'h01);
    cyc(4);
    chk("mode_lp", 11'(mode), 11'h2);
    $display("Mode test done");
    @(posedge ref_clk_i) cur <= 11'h7FF;
    bcr_host_model_i.wr(8'h21, 8'h00);
    cyc(6260);
    rchk("clamp_low", 8'h22, 8'hD0);
    rchk("clamp_high", 8'h21, 8'hE0);
    for (int i = 0; i < 3; i++) begin
        @(posedge ref_clk_i) flt <= 3'h1 << i;
        cyc(2);
        chk("pwrdn", 11'(pdn), 11'h1);
        @(posedge ref_clk_i) flt <= 3'h0;
        rchk("fault_flag", 8'h0E, 8'h01 | (8'h02 << i));
        bcr_host_model_i.wr(8'h0E, 8'hFE);
        rchk("flag_clr", 8'h0E, 8'h01);
    end
    $display("Fault test done");
    bcr_host_model_i.pins(1'b0, 1'b1);
    cyc(2);
    chk("hw_off", 11'(conv), 11'h0);
    bcr_host_model_i.wr(8'h2E, 8'h01);
    rchk("pending", 8'h10, 8'h01);
    rchk("wr_low", 8'h2E, 8'h01);
    @(posedge ref_clk_i) pd_done <= 1'b1;
    @(posedge ref_clk_i) pd_done <= 1'b0;
    rchk("hw_dflt", 8'h10, 8'h00);
    rchk("vset_kept", 8'h00, 8'h80);
    @(posedge ref_clk_i) por_i <= 1'b1;
    @(posedge ref_clk_i) por_i <= 1'b0;
    rchk("por_vset", 8'h00, 8'h00);
    rchk("por_flags", 8'h0E, 8'h00);
    // Supply loss last: no bus transfer may follow it within the wait
    bcr_host_model_i.pins(1'b1, 1'b1);
    @(posedge ref_clk_i) io_lvl <= 1'b0;
    cyc(2);
    chk("io_loss", 11'(pdn), 11'h1);
    @(posedge ref_clk_i) io_lvl <= 1'b1;
    $display("Reset test done");
    final_report();
end
endmodule
